/* File: pkg/pwm_map.svh */
// Purpose: offsets, fields, reset values and codes of the dual-slope pwm timer
// Assumes: 32-bit avalon data, byte addresses, 16-bit registers in the low half
// Notes:   definitions only
`ifndef PWM_MAP_SVH
`define PWM_MAP_SVH

`define OFS_CTRL      5'h00
`define OFS_COUNT     5'h04
`define OFS_CMP_A     5'h08
`define OFS_CMP_B     5'h0C
`define OFS_CAPTURE   5'h10
`define OFS_FLAGS     5'h14
`define OFS_PINS      5'h18
`define OFS_STATUS    5'h1C

`define CTRL_CS_LSB   0
`define CTRL_TOP_LSB  3
`define CTRL_MA_LSB   6
`define CTRL_MB_LSB   8
`define CTRL_RESET    10'h000

`define CS_STOP       3'h0
`define CS_DIV1       3'h1
`define CS_DIV8       3'h2
`define CS_DIV64      3'h3
`define CS_DIV256     3'h4
`define CS_DIV1024    3'h5
`define CS_EXT_FALL   3'h6
`define CS_EXT_RISE   3'h7

`define TOP_FIX8      3'h0
`define TOP_FIX9      3'h1
`define TOP_FIX10     3'h2
`define TOP_CAPTURE   3'h3
`define TOP_CMP_A     3'h4
`define TOP_VAL8      16'h00FF
`define TOP_VAL9      16'h01FF
`define TOP_VAL10     16'h03FF

`define FLAG_OVF      0
`define FLAG_CMP_A    1
`define FLAG_CMP_B    2
`define FLAG_CAPT     3

`define MASK_DIV8     10'h007
`define MASK_DIV64    10'h03F
`define MASK_DIV256   10'h0FF
`define MASK_DIV1024  10'h3FF

`endif

/* File: pkg/pwm_pkg.sv */
// Purpose: shared types of the dual-slope pwm timer
// Assumes: codes of the mode enum equal the two-bit output-mode field
// Notes:   numeric constants live in pwm_map.svh
package pwm_pkg;
    typedef logic [15:0] count_t;
    typedef logic [2:0]  clk_sel_t;
    typedef enum logic [1:0] {
        OUT_PORT,
        OUT_RSVD,
        OUT_CLR_UP,
        OUT_SET_UP
    } out_mode_t;
endpackage : pwm_pkg

/* File: design/prescaler.sv */
// Purpose: divides ref_clk into the internal timer tick
// Assumes: free-running divider shared by all prescale settings
// Notes:   tick is a one-cycle pulse, held high every cycle at divide-by-1, zero when stopped or on external clock
`timescale 1ns/100ps
`include "pwm_map.svh"
module prescaler (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire pwm_pkg::clk_sel_t sel,
    output logic             tick
);
    import pwm_pkg::*;
    logic [9:0] div_q;
    wire  [9:0] mask_w = (sel == `CS_DIV8)    ? `MASK_DIV8 :
                         (sel == `CS_DIV64)   ? `MASK_DIV64 :
                         (sel == `CS_DIV256)  ? `MASK_DIV256 :
                         (sel == `CS_DIV1024) ? `MASK_DIV1024 : 10'h000;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) div_q <= 10'h000;
        else         div_q <= div_q + 10'h001;
    end

    // free running, so a new setting may give one short first period
    assign tick = (sel == `CS_DIV1) || ((mask_w != 10'h000) && ((div_q & mask_w) == mask_w)); // R14

    a_div8_period: assert property (@(posedge ref_clk) disable iff (!resetn || sel != `CS_DIV8) // R14
        tick |=> (!tick)[*7] ##1 tick)
        else $error("divide-by-8 tick spacing wrong");
endmodule : prescaler

/* File: design/edge_sync.sv */
// Purpose: synchronises the external count pin and detects the chosen edge
// Assumes: pin half periods longer than one ref_clk period
// Notes:   tick pulses 1 to 2 cycles after the pin edge, counter one edge later
`timescale 1ns/100ps
module edge_sync (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic pin,
    input  wire logic enable,
    input  wire logic rising,
    output logic      tick
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // only s2/s3 are looked at; s1 may be metastable
    assign tick = enable && (rising ? (s2_q && !s3_q) : (!s2_q && s3_q)); // R15

    a_ext_edge_delay: assert property (@(posedge ref_clk) disable iff (!resetn) // R15
        (enable && rising && $rose(pin)) |-> ##2 tick)
        else $error("external edge not seen two cycles after sampling");
endmodule : edge_sync

/* File: design/dual_slope_pwm_timer.sv */
// Purpose: 16-bit dual-slope pwm timer with avalon-mm register access
// Assumes: one clock, inputs synchronous except external_count_pin
// Notes:   two compare channels a and b on compare_output_n[1:0]
// Contract
// R1: count up to top, down to zero, repeat
// R2: overflow flag set on arriving at zero
// R3: top-source flag set when compares reload
// R4: compare buffers load only at top
// R5: falling slope uses old top, rising new
// R6: fixed top masks compare bits on write
// R7: compare above top never matches
// R8: software keeps new top at or above compares
// R9: software prefers other mode for changing top
// R10: mode 2 gives non-inverted pwm
// R11: mode 3 gives inverted pwm
// R12: up match sets one level, down opposite
// R13: pin driven only when direction is output
// R14: frequency is clock over two, n, top
// R15: external pin synchronised and edge detected
// R16: software toggles external clock on stable pin
// R17: external half period above one cycle
// R18: external clock below clock over 2.5
// R19: external clock bypasses the prescaler
// R20: mode 0 leaves pin to port control
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
`include "pwm_map.svh"
module dual_slope_pwm_timer (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        external_count_pin,
    output logic [1:0]       compare_output_n,
    output logic [1:0]       compare_pin_oe
);
    import pwm_pkg::*;

    function automatic count_t merge16(input count_t old, input logic [31:0] wd, input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    function automatic count_t top_of(input logic [2:0] sel, input count_t cap, input count_t cmp_a);
        case (sel)
            `TOP_FIX8:    top_of = `TOP_VAL8;
            `TOP_FIX9:    top_of = `TOP_VAL9;
            `TOP_FIX10:   top_of = `TOP_VAL10;
            `TOP_CAPTURE: top_of = cap;
            `TOP_CMP_A:   top_of = cmp_a;
            default:      top_of = `TOP_VAL8;
        endcase
    endfunction : top_of

    logic [9:0]  ctrl_q;
    count_t      count_value_q;
    logic        down_q;
    count_t      buf_q [2];
    count_t      compare_reg_n [2];
    count_t      capture_reg_q;
    logic [3:0]  flags_q;
    logic [3:0]  pins_q;
    logic [1:0]  oc_q;
    logic [31:0] rdata_q;
    logic        wait_q;
    logic [1:0]  pin_out_q;
    logic [1:0]  pin_oe_q;

    // bus: first cycle registers read data, second cycle commits the write
    wire       take_w   = (avs_read || avs_write) && wait_q;
    wire       commit_w = avs_write && !wait_q;
    wire       wr_ctrl  = commit_w && (avs_address == `OFS_CTRL);
    wire       wr_count = commit_w && (avs_address == `OFS_COUNT);
    wire       wr_cmp_a = commit_w && (avs_address == `OFS_CMP_A);
    wire       wr_cmp_b = commit_w && (avs_address == `OFS_CMP_B);
    wire       wr_capt  = commit_w && (avs_address == `OFS_CAPTURE);
    wire       wr_flags = commit_w && (avs_address == `OFS_FLAGS) && avs_byteenable[0];
    wire       wr_pins  = commit_w && (avs_address == `OFS_PINS);

    wire [2:0] cs_w      = ctrl_q[`CTRL_CS_LSB +: 3];
    wire [2:0] top_sel_w = ctrl_q[`CTRL_TOP_LSB +: 3];
    wire [1:0] mode_w [2];
    assign mode_w[0] = ctrl_q[`CTRL_MA_LSB +: 2];
    assign mode_w[1] = ctrl_q[`CTRL_MB_LSB +: 2];

    // clock source: prescaled or external, never both
    wire ext_sel_w = (cs_w == `CS_EXT_FALL) || (cs_w == `CS_EXT_RISE);
    wire pre_tick;
    wire ext_tick;
    wire tick_w = ext_sel_w ? ext_tick : pre_tick; // R19

    prescaler u_prescaler (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .sel     (cs_w),
        .tick    (pre_tick)
    );

    edge_sync u_edge_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .pin     (external_count_pin),
        .enable  (ext_sel_w),
        .rising  (cs_w == `CS_EXT_RISE),
        .tick    (ext_tick)
    );

    // counter; a software write to the count wins over counting
    wire count_t top_w   = top_of(top_sel_w, capture_reg_q, compare_reg_n[0]);
    wire         fixed_w = (top_sel_w == `TOP_FIX8) || (top_sel_w == `TOP_FIX9) || (top_sel_w == `TOP_FIX10);
    wire count_t cmask_w = fixed_w ? top_w : 16'hFFFF;
    wire         run_w   = tick_w && !wr_count;
    wire         at_bot  = (count_value_q == 16'h0000);
    wire         turn_dn = run_w && !down_q && (count_value_q >= top_w);
    wire         turn_up = run_w && down_q && at_bot;
    wire         arrive0 = run_w && down_q && (count_value_q == 16'h0001);
    wire count_t cnt_inc = count_value_q + 16'h0001;
    wire count_t cnt_dec = at_bot ? 16'h0000 : count_value_q - 16'h0001;
    wire count_t count_d = wr_count ? merge16(count_value_q, avs_writedata, avs_byteenable) :
                           !run_w   ? count_value_q :
                           turn_dn  ? cnt_dec :
                           turn_up  ? cnt_inc :
                           down_q   ? cnt_dec : cnt_inc; // R1
    wire         down_d  = turn_dn ? 1'b1 : (turn_up ? 1'b0 : down_q); // R1

    // compare match, suppressed when compare lies above top
    wire [1:0] match_w;
    wire [1:0] oc_d;
    wire [1:0] pin_out_d;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            assign match_w[gi]   = run_w && (count_value_q == compare_reg_n[gi])
                                   && (compare_reg_n[gi] <= top_w); // R7
            // mode 2: clear on up match, set on down; mode 3 the reverse
            assign oc_d[gi]      = (match_w[gi] && mode_w[gi][1])
                                   ? (down_q ? (mode_w[gi] == OUT_CLR_UP) : (mode_w[gi] == OUT_SET_UP))
                                   : oc_q[gi]; // R10 R11 R12
            // reserved mode 1 is treated like mode 0 here
            assign pin_out_d[gi] = mode_w[gi][1] ? oc_q[gi] : pins_q[2 + gi]; // R20
        end
    endgenerate

    wire [3:0] flag_set = {turn_dn && (top_sel_w == `TOP_CAPTURE),
                           match_w[1],
                           match_w[0] || (turn_dn && (top_sel_w == `TOP_CMP_A)),
                           arrive0}; // R2 R3
    wire [3:0] flag_clr = wr_flags ? avs_writedata[3:0] : 4'h0;

    wire count_t cmp_wd  = merge16(avs_address == `OFS_CMP_A ? buf_q[0] : buf_q[1], avs_writedata, avs_byteenable);
    wire count_t ctrl_wd = merge16({6'h00, ctrl_q}, avs_writedata, avs_byteenable);

    wire [31:0] rd_w = (avs_address == `OFS_CTRL)    ? {22'h000000, ctrl_q} :
                       (avs_address == `OFS_COUNT)   ? {16'h0000, count_value_q} :
                       (avs_address == `OFS_CMP_A)   ? {16'h0000, buf_q[0]} :
                       (avs_address == `OFS_CMP_B)   ? {16'h0000, buf_q[1]} :
                       (avs_address == `OFS_CAPTURE) ? {16'h0000, capture_reg_q} :
                       (avs_address == `OFS_FLAGS)   ? {28'h0000000, flags_q} :
                       (avs_address == `OFS_PINS)    ? {28'h0000000, pins_q} :
                       (avs_address == `OFS_STATUS)  ? {29'h00000000, oc_q, down_q} : 32'h00000000;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            wait_q  <= !take_w;
            if (take_w) rdata_q <= rd_w;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q        <= `CTRL_RESET;
            capture_reg_q <= 16'h0000;
            pins_q        <= 4'h0;
            flags_q       <= 4'h0;
        end else begin
            if (wr_ctrl) ctrl_q <= ctrl_wd[9:0];
            if (wr_capt) capture_reg_q <= merge16(capture_reg_q, avs_writedata, avs_byteenable);
            if (wr_pins && avs_byteenable[0]) pins_q <= avs_writedata[3:0];
            // a flag event in the clearing cycle survives
            flags_q <= (flags_q & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            count_value_q <= 16'h0000;
            down_q        <= 1'b0;
            oc_q          <= 2'b00;
        end else begin
            count_value_q <= count_d;
            down_q        <= down_d;
            oc_q          <= oc_d;
        end
    end

    // buffered compares; any compare write re-masks both under a fixed top
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            buf_q[0]         <= 16'h0000;
            buf_q[1]         <= 16'h0000;
            compare_reg_n[0] <= 16'h0000;
            compare_reg_n[1] <= 16'h0000;
        end else begin
            if (wr_cmp_a || wr_cmp_b) begin
                buf_q[0] <= (wr_cmp_a ? cmp_wd : buf_q[0]) & cmask_w; // R6
                buf_q[1] <= (wr_cmp_b ? cmp_wd : buf_q[1]) & cmask_w; // R6
            end
            // reload only at top: old top ends the period, new top starts it
            if (turn_dn) begin
                compare_reg_n[0] <= buf_q[0]; // R4 R5
                compare_reg_n[1] <= buf_q[1]; // R4
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pin_out_q <= 2'b00;
            pin_oe_q  <= 2'b00;
        end else begin
            pin_out_q <= pin_out_d;
            pin_oe_q  <= pins_q[1:0]; // R13
        end
    end

    assign avs_readdata     = rdata_q;
    assign avs_waitrequest  = wait_q;
    assign compare_output_n = pin_out_q;
    assign compare_pin_oe   = pin_oe_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_reach_top;
        run_w && !down_q && (count_value_q >= top_w) && (count_value_q != 16'h0000);
    endsequence

    sequence s_leave_top;
        down_q && (count_value_q == $past(count_value_q) - 16'h0001);
    endsequence

    a_turn_at_top: assert property (s_reach_top |=> s_leave_top) // R1
        else $error("counter did not turn down at top");
    a_overflow_bottom: assert property ((run_w && down_q && count_value_q == 16'h0001) // R2
        |=> flags_q[`FLAG_OVF] && at_bot)
        else $error("overflow flag missing at bottom");
    a_top_flag_load: assert property ((turn_dn && top_sel_w == `TOP_CAPTURE) // R3
        |=> flags_q[`FLAG_CAPT] && compare_reg_n[1] == $past(buf_q[1]))
        else $error("capture flag and compare reload not together");
    a_hold_off_top: assert property (!turn_dn |=> $stable(compare_reg_n[0])) // R4
        else $error("compare reloaded away from top");
    a_fixed_mask: assert property ((wr_cmp_a && fixed_w && !wr_ctrl) |=> (buf_q[0] & ~cmask_w) == 16'h0000) // R6
        else $error("compare bits above fixed top not cleared");
    a_no_match_above: assert property ((compare_reg_n[0] > top_w) |-> !match_w[0]) // R7
        else $error("match for compare above top");
    a_noninv_pwm: assert property ((match_w[0] && !down_q && mode_w[0] == OUT_CLR_UP) // R10 R12
        |=> !oc_q[0] ##1 compare_output_n[0] == 1'b0 || mode_w[0] != OUT_CLR_UP)
        else $error("non-inverted pwm level wrong on up match");
    a_inv_pwm: assert property ((match_w[1] && down_q && mode_w[1] == OUT_SET_UP) |=> !oc_q[1]) // R11 R12
        else $error("inverted pwm level wrong on down match");
    a_port_mode: assert property ((mode_w[0] == OUT_PORT) |=> compare_output_n[0] == $past(pins_q[2])) // R20
        else $error("mode 0 pin not under port control");
    a_pin_enable: assert property (##1 compare_pin_oe == $past(pins_q[1:0])) // R13
        else $error("pin enable does not follow direction bits");

    sequence s_at_bottom;
        run_w && down_q && at_bot;
    endsequence

    sequence s_leave_bottom;
        !down_q && (count_value_q == 16'h0001);
    endsequence

    a_turn_at_bottom: assert property (s_at_bottom |=> s_leave_bottom) // R1
        else $error("counter did not turn up at bottom");
    a_count_stopped: assert property ((!run_w && !wr_count) |=> $stable(count_value_q)) // R1
        else $error("counter moved without a tick");
    a_ovf_rise_bottom: assert property ($rose(flags_q[`FLAG_OVF]) |-> at_bot) // R2
        else $error("overflow flag set away from bottom");
    a_cmp_a_flag: assert property ((turn_dn && top_sel_w == `TOP_CMP_A) // R3
        |=> flags_q[`FLAG_CMP_A])
        else $error("compare a flag missing at top reload");
    a_hold_b: assert property (!turn_dn |=> $stable(compare_reg_n[1])) // R4
        else $error("compare b reloaded away from top");
    a_reload_at_top: assert property (turn_dn |=> compare_reg_n[0] == $past(buf_q[0])) // R4 R5
        else $error("compare a not reloaded at top");
    a_fixed_mask_b: assert property ((wr_cmp_b && fixed_w) |=> (buf_q[1] & ~cmask_w) == 16'h0000) // R6
        else $error("compare b bits above fixed top not cleared");
    a_no_match_b: assert property ((compare_reg_n[1] > top_w) |-> !match_w[1]) // R7
        else $error("match for compare b above top");

    a_down_match_a: assert property ((match_w[0] && down_q && mode_w[0] == OUT_CLR_UP) // R10 R12
        |=> oc_q[0])
        else $error("non-inverted pwm level wrong on down match");
    a_up_match_a: assert property ((match_w[0] && !down_q && mode_w[0] == OUT_SET_UP) // R11 R12
        |=> oc_q[0])
        else $error("inverted pwm level wrong on up match");
    a_pwm_to_pin: assert property (mode_w[0][1] |=> compare_output_n[0] == $past(oc_q[0])) // R10 R11
        else $error("pwm level not passed to pin a");
    a_port_mode_b: assert property ((mode_w[1] == OUT_PORT) |=> compare_output_n[1] == $past(pins_q[3])) // R20
        else $error("mode 0 pin b not under port control");
    a_div1_tick: assert property ((cs_w == `CS_DIV1) |-> pre_tick) // R14
        else $error("undivided clock missed a tick");
    a_ext_counts: assert property ((ext_sel_w && ext_tick && !wr_count && top_w != 16'h0000) // R15 R19
        |=> !$stable(count_value_q))
        else $error("external tick did not move the counter");
endmodule : dual_slope_pwm_timer

/* File: bench/ext_clk_source.sv */
// Purpose: external count clock source feeding the timer's count pin
// Assumes: pin rests low between bursts
// Notes:   half period of three ref_clk cycles
`timescale 1ns/100ps
module ext_clk_source #(
    parameter int HALF_NS = 300  // above one cycle, below clock over 2.5
) (
    input  wire logic       start,
    input  wire logic [7:0] pulses,
    output logic            pin
);
    initial pin = 1'b0;
    // bursts only on request, so the pin is stable while the select changes
    always @(posedge start) begin
        #25;  // keeps pin edges clear of the sampling edge
        repeat (pulses) begin
            #HALF_NS pin = 1'b1;
            #HALF_NS pin = 1'b0;
        end
    end
endmodule : ext_clk_source

/* File: bench/dual_slope_pwm_timer_tb.sv */
// Purpose: self-checking bench for the dual-slope pwm timer
// Assumes: one wait cycle per avalon request
// Notes:   slow prescales skipped to keep the run short
`timescale 1ns/100ps
`include "pwm_map.svh"
module dual_slope_pwm_timer_tb;
    import pwm_pkg::*;
    logic        ref_clk, resetn, avs_read, avs_write, avs_waitrequest, start;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic [1:0]  compare_output_n, compare_pin_oe;
    logic [7:0]  pulses;
    wire         external_count_pin;
    int          errors, check_count;

    dual_slope_pwm_timer dut (.ref_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .external_count_pin, .compare_output_n,
        .compare_pin_oe);
    ext_clk_source src (.start(start), .pulses(pulses), .pin(external_count_pin));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task finish_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task wait_ack;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            errors++;
            finish_test();
        end
    endtask : wait_ack

    task wr(input logic [4:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask : wr

    task rdchk(input string nm, input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] d;
        avs_address <= a;
        avs_read    <= 1'b1;
        wait_ack();
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge ref_clk);
        chk(nm, d, exp);
    endtask : rdchk

    // counts edges until channel idx shows level v
    task lvl_wait(input int idx, input logic v, output int n);
        n = 0;
        while (compare_output_n[idx] !== v && n < 20000) begin
            @(posedge ref_clk);
            n++;
        end
        if (compare_output_n[idx] !== v) begin
            errors++;
            finish_test();
        end
    endtask : lvl_wait

    task t_reset;
        chk("waitrequest", avs_waitrequest, 32'h1);
        chk("pins", {compare_pin_oe, compare_output_n}, 32'h0);
        rdchk("ctrl", `OFS_CTRL, 32'h0);
        rdchk("count", `OFS_COUNT, 32'h0);
        rdchk("flags", `OFS_FLAGS, 32'h0);
        rdchk("status", `OFS_STATUS, 32'h0);
        wr(5'h02, 32'h0000FFFF);
        rdchk("unmapped", 5'h02, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task t_ext;
        wr(`OFS_CTRL, 32'h0);
        wr(`OFS_COUNT, 32'h0010);
        for (int e = 0; e < 2; e++) begin
            wr(`OFS_CTRL, e ? 32'(`CS_EXT_FALL) : 32'(`CS_EXT_RISE));
            start <= 1'b1;
            repeat (50) @(posedge ref_clk);  // six pulses at 600 ns need 36 cycles
            start <= 1'b0;
            rdchk("ext count", `OFS_COUNT, 32'h0016 + 32'(6 * e));
        end
        wr(`OFS_CTRL, 32'h0);
        $display("test ext done");
    endtask : t_ext

    task t_pwm;
        int hi, lo, n, scale;
        logic [1:0] mode;
        wr(`OFS_PINS, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk("oe on", compare_pin_oe, 32'h1);
        wr(`OFS_CMP_A, 32'h0080);
        for (int k = 0; k < 3; k++) begin
            scale = (k == 1) ? 8 : 1;
            mode  = (k == 2) ? OUT_SET_UP : OUT_CLR_UP;
            wr(`OFS_CTRL, (32'(mode) << `CTRL_MA_LSB) | (32'(mode) << `CTRL_MB_LSB)
                | ((k == 1) ? 32'(`CS_DIV8) : 32'(`CS_DIV1)));
            for (int s = 0; s < 2; s++) begin
                lvl_wait(0, 1'b0, n);
                lvl_wait(0, 1'b1, n);
            end
            lvl_wait(0, 1'b0, hi);
            lvl_wait(0, 1'b1, lo);
            chk("period", 32'(hi + lo), 32'(510 * scale));
            chk("high time", 32'(hi), 32'((k == 2 ? 254 : 256) * scale));
        end
        $display("test pwm done");
    endtask : t_pwm

    task t_port;
        wr(`OFS_CTRL, 32'h0);
        wr(`OFS_PINS, 32'h5);
        repeat (2) @(posedge ref_clk);
        chk("port high", compare_output_n[0], 32'h1);
        wr(`OFS_PINS, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk("port low", compare_output_n[0], 32'h0);
        wr(`OFS_PINS, 32'hA);
        repeat (2) @(posedge ref_clk);
        chk("port b", {compare_pin_oe, compare_output_n}, 32'hA);
        wr(`OFS_PINS, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk("oe off", compare_pin_oe, 32'h0);
        $display("test port done");
    endtask : t_port

    task t_top;
        wr(`OFS_CTRL, 32'(`TOP_FIX9) << `CTRL_TOP_LSB);
        wr(`OFS_COUNT, 32'h0);  // start at bottom, stale compares matched before the clear
        wr(`OFS_CMP_A, 32'h0000FFFF);
        rdchk("masked cmp", `OFS_CMP_A, 32'h01FF);
        wr(`OFS_CAPTURE, 32'h0040);
        wr(`OFS_CMP_B, 32'h0080);  // above top on purpose
        wr(`OFS_CTRL, (32'(`TOP_CAPTURE) << `CTRL_TOP_LSB) | (32'h2 << `CTRL_MB_LSB) | 32'(`CS_DIV1));
        repeat (20) @(posedge ref_clk);
        wr(`OFS_FLAGS, 32'hF);
        repeat (300) @(posedge ref_clk);
        rdchk("capture top flags", `OFS_FLAGS, 32'h9);
        wr(`OFS_CMP_A, 32'h0030);
        repeat (150) @(posedge ref_clk);  // let the new compare a load at top first
        wr(`OFS_CTRL, (32'(`TOP_CMP_A) << `CTRL_TOP_LSB) | 32'(`CS_DIV1));
        repeat (20) @(posedge ref_clk);
        wr(`OFS_FLAGS, 32'hF);
        repeat (200) @(posedge ref_clk);
        rdchk("cmp a top flags", `OFS_FLAGS, 32'h3);
        $display("test top done");
    endtask : t_top

    initial begin
        resetn         = 1'b0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_address    = 5'h00;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hF;
        start          = 1'b0;
        pulses         = 8'h06;
        errors         = 0;
        check_count    = 0;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_ext();
        t_pwm();
        t_port();
        t_top();
        finish_test();
    end
endmodule : dual_slope_pwm_timer_tb
